/* File: core/sspr_pkg.sv */
/*
 * Constants and types shared by the slave-side addressing and receive logic.
 * Assumes a single system clock; bus pins are sampled, never used as clocks.
 */
// What this block does
// - A repeated start resets slave state like a start, awaiting an address byte.
// - In 10-bit mode, a read high byte after a full match holds SCL for data.
// - A 10-bit write match sets prior-match until stop, write high byte or mismatch.
// - Start and stop interrupt enables raise the flag only in non-interrupting modes.
// - Ninth SCL pulse is the active-low acknowledge slot, driven by the receiver.
// - The acknowledge level seen on the ninth pulse is kept in the status bit.
// - With holds enabled, software's acknowledge value is sent to the master.
// - With both holds clear, hardware generates the acknowledge itself.
// - Where hardware acknowledges, buffer full forces a not-acknowledge; overflow does so unless overwrite is enabled.
// - Acknowledge-time flag sets after the eighth fall, only with a hold enabled.
// - Four slave modes; interrupting ones flag every start, restart and stop.
// - First byte after start is matched against the address; in 7-bit mode a match is then buffered.
// - A 7-bit or 10-bit high byte address mismatch returns to idle without raising the interrupt flag.
// - In 7-bit mode the address byte's lowest bit is not compared.
// - A 10-bit high byte is matched against 11110, address bits 2 and 1, then 0, or 1 after a prior match.
// - After the high byte, update-address sets and SCL holds until address rewrite.
// - The low byte sets flag and update-address even on mismatch; a rewrite clears it.
// - A matching write address clears direction, is buffered and acknowledged.
// - Every acknowledged byte raises the interrupt flag until software clears it.
// - With stretch enabled, SCL holds after each received byte except the 10-bit address bytes, until release.
// - With a hold enabled, eighth fall sets the flag and clears clock release.
// - With a hold enabled, the ninth fall sets the flag again unless not-acknowledged.
// - SDA is sampled on SCL rise; SDA changes while SCL high are start or stop.
// - A stop counts only after one SCL low period following the start.
package sspr_pkg;

	// Slave mode selections, two bits wide.
	localparam logic [1:0] MODE_7BIT = 2'h0;
	localparam logic [1:0] MODE_10BIT = 2'h1;
	localparam logic [1:0] MODE_7BIT_IRQ = 2'h2;
	localparam logic [1:0] MODE_10BIT_IRQ = 2'h3;
	localparam int MODE_IRQ_BIT = 1;
	localparam int MODE_TEN_BIT = 0;

	// Bit counter values and 10-bit header pattern.
	localparam logic [3:0] CNT_LAST_DATA = 4'h7;
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic [4:0] TEN_HEADER = 5'h1e;
	localparam int ADDR_HI_MSB = 2;
	localparam int ADDR_HI_LSB = 1;

	// Values after reset.
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic CKP_RESET = 1'b1;

	// Receive buffer shape.
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_LO, ST_DATA, ST_READ} sspr_state_t;

endpackage : sspr_pkg

/* File: core/sspr_i2c_slave.sv */
/*
 * Receive buffer FIFO and the slave addressing and receive engine.
 * Assumes SCL and SDA arrive asynchronously from an open-drain bus and that
 * control bits are written by logic on the same clock.
 */
`timescale 1ns/1ps

// Synchronous FIFO; full and empty come from flip-flops.
module sspr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic full_q, full_d, empty_q, empty_d;
	logic push, pop;

	// Pointer and level updates; a push while full is refused.
	always_comb begin
		push = in_valid && !full_q;
		pop = out_ready && !empty_q;
		wp_d = push ? wp_q + AW'(1) : wp_q;
		rp_d = pop ? rp_q + AW'(1) : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		full_d = (cnt_d == (AW+1)'(DEPTH));
		empty_d = (cnt_d == '0);
	end

	// Registers; storage has no reset since empty gates its use.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			full_q <= full_d;
			empty_q <= empty_d;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	assign in_ready = !full_q;
	assign out_valid = !empty_q;
	assign out_data = mem_q[rp_q];

	fifo_level_a: assert property (@(posedge clock) disable iff (!rst_n)
		push && !pop |=> cnt_q == $past(cnt_q) + 1'b1) else $error("fifo level wrong");
endmodule : sspr_fifo

// Slave addressing and receive engine.
module sspr_i2c_slave (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe_n,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [1:0] port_mode_sel,
	input wire logic start_irq_en,
	input wire logic stop_irq_en,
	input wire logic address_hold_en,
	input wire logic data_hold_en,
	input wire logic stretch_en,
	input wire logic buffer_overwrite_en,
	input wire logic ack_value_bit,
	input wire logic address_wr,
	input wire logic [7:0] address_wdata,
	input wire logic clock_release_set,
	input wire logic irq_clear,
	input wire logic overflow_clear,
	output logic [7:0] slave_address_reg,
	output logic serial_irq_flag,
	output logic update_address_flag,
	output logic ack_time_flag,
	output logic ack_status_bit,
	output logic overflow_flag,
	output logic buffer_full_flag,
	output logic clock_release_bit,
	output logic read_dir_bit,
	output logic data_byte_bit,
	output logic prior_match_flag,
	output logic start_seen,
	output logic stop_seen,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	logic scl_rise, scl_fall, start_det, stop_det;

	sspr_pkg::sspr_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, adr_q, adr_d;
	logic low_q, low_d, irq_q, irq_d, ua_q, ua_d, ackt_q, ackt_d, acks_q, acks_d;
	logic ov_q, ov_d, ckp_q, ckp_d, rw_q, rw_d, da_q, da_d, pm_q, pm_d;
	logic ss_q, ss_d, ps_q, ps_d, sdrv_q, sdrv_d, pend_q, pend_d;
	logic ok_q, ok_d, push_q, push_d, sclo_q, sclo_d;
	logic fifo_ready, irq_mode, ten, hold_en, block, match;
	logic [7:0] push_data_q;

	// Reset release through two flip-flops.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Pin synchronisers plus one stage for edge finding.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
		end else begin
			{scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
		end
	end

	always_comb begin
		scl_rise = scl_s_q && !scl_p_q;
		scl_fall = !scl_s_q && scl_p_q;
		start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
		// Stop needs an SCL low period since the start.
		stop_det = scl_s_q && scl_p_q && !sda_p_q && sda_s_q && low_q;
		irq_mode = port_mode_sel[sspr_pkg::MODE_IRQ_BIT];
		ten = port_mode_sel[sspr_pkg::MODE_TEN_BIT];
	end

	// Byte-level decisions, taken from the completed shift register at the eighth fall.
	always_comb begin
		hold_en = (st_q == sspr_pkg::ST_DATA) ? data_hold_en : address_hold_en;
		// Full buffer refuses the byte; overflow does so unless overwrite is enabled.
		block = (buffer_full_flag || ov_q) && !buffer_overwrite_en || !fifo_ready;
		match = 1'b0;
		unique case (st_q)
			sspr_pkg::ST_ADDR: begin
				if (ten) begin
					match = sh_q[7:3] == sspr_pkg::TEN_HEADER
						&& sh_q[2:1] == adr_q[sspr_pkg::ADDR_HI_MSB:sspr_pkg::ADDR_HI_LSB]
						&& (!sh_q[0] || pm_q);
				end else begin
					match = sh_q[7:1] == adr_q[7:1];
				end
			end
			// Low byte compared on all eight bits.
			sspr_pkg::ST_ADDR_LO: match = sh_q == adr_q;
			sspr_pkg::ST_DATA: match = 1'b1;
			sspr_pkg::ST_IDLE, sspr_pkg::ST_READ: match = 1'b0;
		endcase
	end

	// Main engine next-state logic.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		adr_d = adr_q;
		low_d = low_q;
		irq_d = irq_q && !irq_clear;
		ua_d = ua_q;
		ackt_d = ackt_q;
		acks_d = acks_q;
		ov_d = ov_q && !overflow_clear;
		ckp_d = ckp_q || clock_release_set;
		rw_d = rw_q;
		da_d = da_q;
		pm_d = pm_q;
		ss_d = ss_q;
		ps_d = ps_q;
		sdrv_d = sdrv_q;
		pend_d = pend_q;
		ok_d = ok_q;
		push_d = 1'b0;
		if (address_wr) begin
			adr_d = address_wdata;
			ua_d = 1'b0;
		end
		// Low period since the start. The fall right after a start is no bit clock,
		// so falls are only counted once this flag is up.
		if (!scl_s_q) begin
			low_d = 1'b1;
		end
		// Software acknowledge sent once the clock is released.
		if (pend_q && clock_release_set) begin
			pend_d = 1'b0;
			sdrv_d = !ack_value_bit;
		end
		if (start_det) begin
			// Start or restart resets the slave and awaits an address.
			st_d = sspr_pkg::ST_ADDR;
			cnt_d = '0;
			low_d = 1'b0;
			sdrv_d = 1'b0;
			pend_d = 1'b0;
			ackt_d = 1'b0;
			ss_d = 1'b1;
			ps_d = 1'b0;
			// Optional start interrupt; always in interrupting modes.
			if (irq_mode || start_irq_en) begin
				irq_d = 1'b1;
			end
		end else if (stop_det) begin
			st_d = sspr_pkg::ST_IDLE;
			cnt_d = '0;
			sdrv_d = 1'b0;
			pend_d = 1'b0;
			ackt_d = 1'b0;
			pm_d = 1'b0;
			ss_d = 1'b0;
			ps_d = 1'b1;
			if (irq_mode || stop_irq_en) begin
				irq_d = 1'b1;
			end
		end else if (st_q != sspr_pkg::ST_IDLE && st_q != sspr_pkg::ST_READ) begin
			if (scl_rise) begin
				if (cnt_q < sspr_pkg::CNT_ACK) begin
					sh_d = {sh_q[6:0], sda_s_q};
				end else begin
					// Acknowledge level as seen on the bus.
					acks_d = sda_s_q;
				end
			end else if (scl_fall && low_q && cnt_q < sspr_pkg::CNT_LAST_DATA) begin
				cnt_d = cnt_q + 4'h1;
			end else if (scl_fall && low_q && cnt_q == sspr_pkg::CNT_LAST_DATA) begin
				// Eighth fall: the byte is complete.
				cnt_d = sspr_pkg::CNT_ACK;
				ok_d = match && !block;
				if (match && block && (buffer_full_flag || ov_q)) begin
					ov_d = 1'b1;
				end
				if (st_q == sspr_pkg::ST_ADDR && ten) begin
					// Write high byte or failed match ends prior match.
					if (!match || !sh_q[0]) begin
						pm_d = 1'b0;
					end
				end
				if (match && !block && !(st_q == sspr_pkg::ST_ADDR && ten)) begin
					// Matching byte loaded into the buffer.
					push_d = 1'b1;
				end
				if (match && st_q != sspr_pkg::ST_DATA) begin
					// Direction bit from the address byte.
					rw_d = sh_q[0] && st_q == sspr_pkg::ST_ADDR;
					da_d = 1'b0;
				end else if (match) begin
					da_d = 1'b1;
				end
				if (match && (address_hold_en || data_hold_en) && hold_en) begin
					// Extra interrupt and stretch; acknowledge time.
					irq_d = 1'b1;
					ckp_d = 1'b0;
					ackt_d = 1'b1;
					pend_d = 1'b1;
				end else begin
					// Hardware acknowledge; driven low in the slot.
					sdrv_d = match && !block;
				end
			end else if (scl_fall && low_q && cnt_q == sspr_pkg::CNT_ACK) begin
				// Ninth fall: acknowledge slot over.
				cnt_d = '0;
				sdrv_d = 1'b0;
				pend_d = 1'b0;
				ackt_d = 1'b0;
				// Flag again unless a not-acknowledge went out.
				if (sdrv_q) begin
					irq_d = 1'b1;
				end
				unique case (st_q)
					sspr_pkg::ST_ADDR: begin
						if (!sdrv_q) begin
							st_d = sspr_pkg::ST_IDLE;
						end else if (rw_q) begin
							// Read request: hold SCL for outgoing data.
							st_d = sspr_pkg::ST_READ;
							ckp_d = 1'b0;
						end else if (ten) begin
							st_d = sspr_pkg::ST_ADDR_LO;
							ua_d = 1'b1;
						end else begin
							st_d = sspr_pkg::ST_DATA;
							ckp_d = ckp_d && !stretch_en;
						end
					end
					sspr_pkg::ST_ADDR_LO: begin
						// Flag and update-address even on mismatch.
						irq_d = 1'b1;
						ua_d = 1'b1;
						st_d = ok_q && sdrv_q ? sspr_pkg::ST_DATA : sspr_pkg::ST_IDLE;
						// Full write match sets prior match.
						pm_d = ok_q;
					end
					sspr_pkg::ST_DATA: begin
						if (stretch_en) begin
							ckp_d = 1'b0;
						end
					end
					default: st_d = st_q;
				endcase
			end
		end
		// SCL is held while release is pending or the address needs updating.
		sclo_d = ckp_d && !ua_d;
	end

	// Engine registers.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= sspr_pkg::ST_IDLE;
			cnt_q <= '0;
			sh_q <= '0;
			adr_q <= sspr_pkg::ADDR_RESET;
			{low_q, irq_q, ua_q, ackt_q, acks_q, ov_q} <= 6'h00;
			ckp_q <= sspr_pkg::CKP_RESET;
			{rw_q, da_q, pm_q, ss_q, ps_q, sdrv_q, pend_q, ok_q, push_q} <= 9'h000;
			sclo_q <= 1'b1;
			push_data_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			adr_q <= adr_d;
			{low_q, irq_q, ua_q, ackt_q, acks_q, ov_q} <=
				{low_d, irq_d, ua_d, ackt_d, acks_d, ov_d};
			ckp_q <= ckp_d;
			{rw_q, da_q, pm_q, ss_q, ps_q, sdrv_q, pend_q, ok_q, push_q} <=
				{rw_d, da_d, pm_d, ss_d, ps_d, sdrv_d, pend_d, ok_d, push_d};
			sclo_q <= sclo_d;
			push_data_q <= sh_q;
		end
	end

	// Receive buffer; when full it refuses bytes, which the hardware acknowledge turns into a not-acknowledge.
	sspr_fifo #(
		.WIDTH(sspr_pkg::FIFO_WIDTH),
		.DEPTH(sspr_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(push_q),
		.in_data(push_data_q),
		.in_ready(fifo_ready),
		.out_valid(rx_valid),
		.out_data(rx_data),
		.out_ready(rx_ready)
	);

	// Outputs straight from flip-flops; pins only ever pull low.
	assign buffer_full_flag = !fifo_ready;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = sclo_q;
	assign sda_oe_n = !sdrv_q;
	assign slave_address_reg = adr_q;
	assign serial_irq_flag = irq_q;
	assign update_address_flag = ua_q;
	assign ack_time_flag = ackt_q;
	assign ack_status_bit = acks_q;
	assign overflow_flag = ov_q;
	assign clock_release_bit = ckp_q;
	assign read_dir_bit = rw_q;
	assign data_byte_bit = da_q;
	assign prior_match_flag = pm_q;
	assign start_seen = ss_q;
	assign stop_seen = ps_q;

	restart_resets_a: assert property (@(posedge clock) disable iff (!rst_n)
		start_det |=> st_q == sspr_pkg::ST_ADDR && cnt_q == 4'h0) else $error("restart not reset");
	read_holds_a: assert property (@(posedge clock) disable iff (!rst_n)
		st_q == sspr_pkg::ST_READ && $past(st_q) != sspr_pkg::ST_READ |-> !scl_oe_n)
		else $error("read not held");
	prior_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
		stop_det |=> !pm_q) else $error("prior match kept over stop");
	start_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
		start_det && (irq_mode || start_irq_en) |=> irq_q) else $error("start irq missing");
	ack_slot_a: assert property (@(posedge clock) disable iff (!rst_n)
		!sda_oe_n |-> cnt_q == sspr_pkg::CNT_ACK) else $error("sda driven outside slot");
	ack_status_a: assert property (@(posedge clock) disable iff (!rst_n)
		scl_rise && cnt_q == sspr_pkg::CNT_ACK && !start_det && !stop_det
		&& st_q inside {sspr_pkg::ST_ADDR, sspr_pkg::ST_ADDR_LO, sspr_pkg::ST_DATA}
		|=> ack_status_bit == $past(sda_s_q)) else $error("ack status wrong");
	ack_time_a: assert property (@(posedge clock) disable iff (!rst_n)
		ack_time_flag |-> address_hold_en || data_hold_en || $past(ack_time_flag))
		else $error("ack time without hold");
	mismatch_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
		scl_fall && cnt_q == sspr_pkg::CNT_LAST_DATA && st_q == sspr_pkg::ST_ADDR && !match
		&& !start_det && !stop_det |=> !push_q ##1 !push_q) else $error("mismatch buffered");
	ua_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		address_wr |=> !ua_q || $past(scl_fall)) else $error("address write kept ua");
	stretch_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		!clock_release_bit |-> !scl_oe_n) else $error("scl not stretched");
endmodule : sspr_i2c_slave

/* File: bench/sspr_master_model.sv */
/*
 * Behavioural bus master for the slave receive bench: start, stop and bytes.
 * Assumes open-drain wires resolved by the bench, high while nobody pulls.
 */
`timescale 1ns/1ps

// Bit-banged master; a pull output high means that wire is driven low.
module sspr_master_model (
	input wire logic clock,
	input wire logic scl_wire,
	input wire logic sda_wire,
	output logic scl_pull,
	output logic sda_pull
);
	// Both lines are released at time zero so the bus starts idle.
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end

	// One quarter of a bit, two system clocks.
	task automatic q();
		repeat (2) @(posedge clock);
		#1;
	endtask : q

	// Release SCL and wait, bounded, while the slave stretches it.
	task automatic rise();
		int n;
		n = 0;
		scl_pull = 1'b0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (scl_wire !== 1'b1 && n < 4000);
		q();
	endtask : rise

	task automatic bit_io(input logic b, output logic v);
		sda_pull = ~b;
		q();
		rise();
		v = sda_wire;
		@(posedge clock);
		#1;
		scl_pull = 1'b1;
		q();
	endtask : bit_io

	task automatic start();
		sda_pull = 1'b0;
		q();
		rise();
		sda_pull = 1'b1;
		q();
		scl_pull = 1'b1;
		q();
	endtask : start

	// Stop: SDA rises while SCL is high, after at least one SCL low time.
	task automatic stop();
		sda_pull = 1'b1;
		q();
		rise();
		sda_pull = 1'b0;
		q();
	endtask : stop

	task automatic glitch();
		sda_pull = 1'b1;
		q();
		sda_pull = 1'b0;
		q();
	endtask : glitch

	task automatic send(input logic [7:0] b, output logic ack);
		logic v;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], v);
		end
		bit_io(1'b1, ack);
	endtask : send
endmodule : sspr_master_model

/* File: bench/i2c_slave_address_receive_bench.sv */
/*
 * Self-checking bench for the slave addressing and receive engine.
 * Assumes the master model in its own file; both wires have pull-ups here.
 */
`timescale 1ns/1ps

module i2c_slave_address_receive_bench;
	logic clock, arst_n, m_scl, m_sda, scl_w, sda_w, scl_oe_n, sda_oe_n;
	logic [1:0] mode;
	logic sie, pie, ahe, dhe, str, owen, ackv, awr, rls, iclr, oclr, rx_ready;
	logic [7:0] awd, sar, rx_data, a7, d;
	logic irq, uaf, atf, acks, ovf, full, crb, rdir, dab, pmf, ss, ps, rx_valid, ack;
	logic [7:0] exp_q[$];
	int errors, checked, n, i;

	// Open-drain resolution: any party pulling wins, otherwise the pull-up.
	assign scl_w = ~(m_scl | ~scl_oe_n);
	assign sda_w = ~(m_sda | ~sda_oe_n);

	sspr_master_model m_u (.clock(clock), .scl_wire(scl_w), .sda_wire(sda_w),
		.scl_pull(m_scl), .sda_pull(m_sda));

	sspr_i2c_slave dut_u (.clock(clock), .arst_n(arst_n), .scl_in(scl_w), .sda_in(sda_w),
		.scl_out(), .scl_oe_n(scl_oe_n), .sda_out(), .sda_oe_n(sda_oe_n),
		.port_mode_sel(mode), .start_irq_en(sie), .stop_irq_en(pie),
		.address_hold_en(ahe), .data_hold_en(dhe), .stretch_en(str),
		.buffer_overwrite_en(owen), .ack_value_bit(ackv), .address_wr(awr),
		.address_wdata(awd), .clock_release_set(rls), .irq_clear(iclr),
		.overflow_clear(oclr), .slave_address_reg(sar), .serial_irq_flag(irq),
		.update_address_flag(uaf), .ack_time_flag(atf), .ack_status_bit(acks),
		.overflow_flag(ovf), .buffer_full_flag(full), .clock_release_bit(crb),
		.read_dir_bit(rdir), .data_byte_bit(dab), .prior_match_flag(pmf),
		.start_seen(ss), .stop_seen(ps), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready));

	// Free-running 25 MHz system clock.
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// All bench drives land one nanosecond after a rising edge.
	task automatic tick();
		@(posedge clock);
		#1;
	endtask : tick

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic chkb(input logic g, input logic e);
		chk({7'h00, g}, {7'h00, e});
	endtask : chkb

	task automatic wr_a(input logic [7:0] a);
		awd = a;
		awr = 1'b1;
		tick();
		awr = 1'b0;
	endtask : wr_a

	task automatic rel_clk();
		rls = 1'b1;
		tick();
		rls = 1'b0;
	endtask : rel_clk

	task automatic clr();
		iclr = 1'b1;
		tick();
		iclr = 1'b0;
	endtask : clr

	// One byte with its acknowledge; a buffered byte joins the expected queue.
	task automatic tx(input logic [7:0] b, input logic ea, input logic p);
		m_u.send(b, ack);
		repeat (3) tick();
		chkb(ack, ea);
		if (p) exp_q.push_back(b);
	endtask : tx

	// Drain the buffer in order; the master is idle and SCL may be held meanwhile.
	task automatic drain();
		rx_ready = 1'b1;
		while (exp_q.size() > 0) begin
			n = 0;
			while (rx_valid !== 1'b1 && n < 50) begin
				tick();
				n++;
			end
			chk(rx_data, exp_q.pop_front());
			tick();
		end
		rx_ready = 1'b0;
		tick();
		chkb(rx_valid, 1'b0);
	endtask : drain

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// Watchdog: far beyond the few thousand cycles the sequence needs.
	initial begin
		repeat (40000) @(posedge clock);
		errors++;
		end_of_test();
	end

	// Main sequence: reset, then one scenario after another.
	initial begin
		arst_n = 1'b0;
		{mode, sie, pie, ahe, dhe, str, owen, ackv, awr, rls, iclr, oclr, rx_ready} = '0;
		awd = 8'h00;
		errors = 0;
		checked = 0;
		void'($urandom(32'h3ef5));
		repeat (12) @(posedge clock);
		#1;
		arst_n = 1'b1;
		repeat (3) tick();
		chk(sar, 8'h00);
		chkb(crb, 1'b1);
		a7 = 8'($urandom) & 8'hfe;
		wr_a(a7 | 8'h01);
		m_u.start();
		repeat (4) tick();
		chkb(ss, 1'b1);
		chkb(irq, 1'b0);
		tx(a7, 1'b0, 1'b1);
		chkb(acks, 1'b0);
		chkb(rdir, 1'b0);
		chkb(irq, 1'b1);
		chkb(atf, 1'b0);
		for (i = 0; i < 3; i++) begin
			clr();
			tx(8'($urandom), 1'b0, 1'b1);
			chkb(irq, 1'b1);
			chkb(dab, 1'b1);
		end
		clr();
		m_u.start();
		tx(a7 ^ 8'h02, 1'b1, 1'b0);
		chkb(irq, 1'b0);
		chkb(acks, 1'b1);
		m_u.stop();
		repeat (4) tick();
		chkb(ps, 1'b1);
		chkb(ss, 1'b0);
		drain();
		// Every mode with the extra enables off and on.
		for (i = 0; i < 8; i++) begin
			mode = 2'(i >> 1);
			sie = i[0];
			pie = i[0];
			clr();
			m_u.start();
			repeat (4) tick();
			chkb(irq, mode[1] | sie);
			clr();
			m_u.stop();
			repeat (4) tick();
			chkb(irq, mode[1] | pie);
		end
		{mode, sie, pie} = '0;
		m_u.glitch();
		repeat (4) tick();
		chkb(ss, 1'b1);
		chkb(ps, 1'b0);
		// Fill the buffer while nobody reads it.
		m_u.start();
		tx(a7, 1'b0, 1'b1);
		for (i = 0; i < 15; i++) begin
			tx(8'($urandom), 1'b0, 1'b1);
		end
		chkb(full, 1'b1);
		tx(8'($urandom), 1'b1, 1'b0);
		chkb(ovf, 1'b1);
		m_u.stop();
		drain();
		// Overflow stays until cleared and would refuse every later byte.
		oclr = 1'b1;
		tick();
		oclr = 1'b0;
		chkb(ovf, 1'b0);
		// Software acknowledge: accept the address, refuse the data byte.
		// Both bytes are buffered at the eighth fall, before software decides.
		ahe = 1'b1;
		dhe = 1'b1;
		clr();
		m_u.start();
		for (i = 0; i < 2; i++) begin
			d = i[0] ? 8'($urandom) : a7;
			fork
				m_u.send(d, ack);
				begin
					n = 0;
					while (atf !== 1'b1 && n < 200) begin
						tick();
						n++;
					end
					chkb(irq, 1'b1);
					chkb(crb, 1'b0);
					clr();
					ackv = i[0];
					rel_clk();
				end
			join
			chkb(ack, i[0]);
			repeat (3) tick();
			chkb(irq, ~i[0]);
			exp_q.push_back(d);
		end
		m_u.stop();
		{ahe, dhe, ackv} = '0;
		drain();
		// Stretch after a received byte until software releases the clock.
		str = 1'b1;
		m_u.start();
		tx(a7, 1'b0, 1'b1);
		rel_clk();
		tx(8'($urandom), 1'b0, 1'b1);
		chkb(scl_oe_n, 1'b0);
		rel_clk();
		tick();
		chkb(scl_oe_n, 1'b1);
		m_u.stop();
		str = 1'b0;
		drain();
		// Ten-bit write match, then restart as a read, then a failed low byte.
		mode = 2'h1;
		d = {5'h1e, 2'($urandom), 1'b0};
		wr_a(d);
		m_u.start();
		tx(d, 1'b0, 1'b0);
		chkb(uaf, 1'b1);
		chkb(scl_oe_n, 1'b0);
		wr_a(a7 ^ 8'h01);
		chkb(uaf, 1'b0);
		tx(a7 ^ 8'h01, 1'b0, 1'b1);
		chkb(pmf, 1'b1);
		wr_a(d);
		m_u.start();
		tx(d | 8'h01, 1'b0, 1'b0);
		chkb(rdir, 1'b1);
		chkb(scl_oe_n, 1'b0);
		rel_clk();
		m_u.start();
		tx(d, 1'b0, 1'b0);
		chkb(pmf, 1'b0);
		wr_a(a7);
		clr();
		tx(a7 ^ 8'h10, 1'b1, 1'b0);
		chkb(irq, 1'b1);
		chkb(uaf, 1'b1);
		wr_a(d);
		m_u.stop();
		drain();
		end_of_test();
	end
endmodule : i2c_slave_address_receive_bench
